// >>> gateway_cmd_map.svh
`ifndef GATEWAY_CMD_MAP_SVH
`define GATEWAY_CMD_MAP_SVH

// ----------------------------------------------------------------
// command selector codes, byte 0 of the send buffer
// ----------------------------------------------------------------
`define CMD_ECHO_LIST   8'h33
`define CMD_CTT2        8'h44
`define CMD_VERSION     8'h14
`define CMD_READ_ID     8'h17
`define CMD_READ_XID1   8'h37
`define CMD_WRITE_XID1  8'h3F

// ----------------------------------------------------------------
// job and reply layout
// ----------------------------------------------------------------
`define ECHO_ARG        8'h00
`define POS_CMD         8'h00
`define POS_ADDR        8'h01
`define POS_LEN         8'h02
`define HDR_LEN         8'h03
`define JOB_MAX         8'hDF
`define REPLY_MAX       8'hDC
`define ECHO_LEN        8'h20
`define VERSION_LEN     8'h20
`define SLAVE_ZERO      6'h00

// ----------------------------------------------------------------
// timing: job timeout in seconds and clock rate in hertz
// ----------------------------------------------------------------
`define JOB_TIMEOUT_S   64'h0000_0000_0000_001E
`define CLOCK_HZ        64'h0000_0000_0773_5940
`define JOB_TIMEOUT_CYC (`JOB_TIMEOUT_S * `CLOCK_HZ)

`endif

// >>> gateway_cmd_pkg.sv
package gateway_cmd_pkg;

	// ------------------------------------------------------------
	// operations passed to the slave line engine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LINE_STRING,
		LINE_READ_ID,
		LINE_READ_XID1,
		LINE_WRITE_XID1
	} line_op_type;

	typedef logic [7:0] byte_type;
	typedef logic [5:0] slave_addr_type;

endpackage

// >>> gateway_job_if.sv
`timescale 1ns/1ps

interface gateway_job_if;

	// ------------------------------------------------------------
	// job stream host to gateway, reply stream gateway to host
	// ------------------------------------------------------------
	logic       job_valid;
	logic [7:0] job_data;
	logic       job_last;
	logic       job_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_last;
	logic       rsp_ready;
	logic       done;
	logic       fail;

	modport gateway (
		input  job_valid, job_data, job_last, rsp_ready,
		output job_ready, rsp_valid, rsp_data, rsp_last, done, fail
	);

	modport host (
		output job_valid, job_data, job_last, rsp_ready,
		input  job_ready, rsp_valid, rsp_data, rsp_last, done, fail
	);

endinterface

// >>> gateway_cmd.sv
// Summary of operation
// R1: echo code with zero arg returns packed echoes
// R2: echo value is last parameter call reply
// R3: CTT2 job: code, address, length, then bytes
// R4: host caps whole CTT2 job at 223 bytes
// R5: CTT2 reply: count byte, then string bytes
// R6: string content opaque, starts at byte three
// R7: suspend cyclic exchange with slave during strings
// R8: host waits about thirty seconds before failing
// R9: version query returns 32-byte name and version
// R10: slave ID read returns low nibble code
// R11: extended ID1 read returns low nibble code
// R12: identification reads are diagnostic, host optional
// R13: ID1 write sends low nibble to address zero
// R14: ID1 value forwarded without any check
// R15: decode byte 0, one job at a time
`timescale 1ns/1ps

module gateway_cmd
	import gateway_cmd_pkg::*;
#(
	// arbitrary text, 32 bytes, first character in the top byte
	parameter logic [255:0] VERSION_TEXT = "gateway firmware 0.0            "
) (
	input  wire logic           clock_i,
	input  wire logic           rst_b_i,
	gateway_job_if.gateway      job,
	output      logic           line_req_valid_o,
	output      line_op_type    line_op_o,
	output      slave_addr_type line_addr_o,
	output      logic [7:0]     line_data_o,
	output      logic           line_last_o,
	input  wire logic           line_req_ready_i,
	input  wire logic           line_rsp_valid_i,
	input  wire logic [7:0]     line_rsp_data_i,
	input  wire logic           line_rsp_last_i,
	input  wire logic           echo_valid_i,
	input  wire slave_addr_type echo_addr_i,
	input  wire logic [3:0]     echo_value_i,
	output      logic           cyclic_hold_o,
	output      slave_addr_type cyclic_hold_addr_o
);

`include "gateway_cmd_map.svh"

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DISPATCH,
		ST_LINE_REQ,
		ST_LINE_WAIT,
		ST_RESPOND
	} state_type;

	state_type  state_q;
	logic [7:0] job_buf_q [223];
	logic [7:0] reply_buf_q [221];
	logic [3:0] echo_q [64];
	logic [7:0] job_cnt_q;
	logic [7:0] send_idx_q;
	logic [7:0] send_end_q;
	logic [7:0] reply_cnt_q;
	logic       reply_ovf_q;
	logic [3:0] id_code_q;
	logic [7:0] rsp_len_q;
	logic [7:0] rsp_idx_q;
	logic       err_q;
	logic       job_ready_q;
	logic       rsp_valid_q;
	logic [7:0] rsp_data_q;
	logic       rsp_last_q;
	logic       done_q;
	logic       fail_q;
	logic [7:0] rsp_byte;
	logic       rsp_free;
	logic       rsp_end;
	logic [8:0] ctt2_end;

	assign job.job_ready = job_ready_q;
	assign job.rsp_valid = rsp_valid_q;
	assign job.rsp_data  = rsp_data_q;
	assign job.rsp_last  = rsp_last_q;
	assign job.done      = done_q;
	assign job.fail      = fail_q;

	// ------------------------------------------------------------
	// parameter echo store
	// ------------------------------------------------------------
	// every parameter call reply overwrites that slave's echo
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 64; i++) begin
				echo_q[i] <= 4'h0;
			end
		end else if (echo_valid_i) begin
			echo_q[echo_addr_i] <= echo_value_i; // R2
		end
	end

	// ------------------------------------------------------------
	// job intake
	// ------------------------------------------------------------
	// ready only in idle, so a second job waits for the first
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			job_ready_q <= 1'b0;
			job_cnt_q   <= 8'h00;
		end else if (state_q != ST_IDLE) begin
			job_ready_q <= 1'b0; // R15
		end else if (job_ready_q && job.job_valid) begin
			if (job_cnt_q < `JOB_MAX) begin
				job_buf_q[job_cnt_q] <= job.job_data;
				job_cnt_q            <= job_cnt_q + 8'h01;
			end
			job_ready_q <= !job.job_last;
		end else if (!job_ready_q) begin
			job_ready_q <= 1'b1;
			job_cnt_q   <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// command state machine and line requests
	// ------------------------------------------------------------
	assign ctt2_end = {1'b0, job_buf_q[`POS_LEN]} + {1'b0, `HDR_LEN};

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_q            <= ST_IDLE;
			line_req_valid_o   <= 1'b0;
			line_op_o          <= LINE_STRING;
			line_addr_o        <= `SLAVE_ZERO;
			line_data_o        <= 8'h00;
			line_last_o        <= 1'b0;
			cyclic_hold_o      <= 1'b0;
			cyclic_hold_addr_o <= `SLAVE_ZERO;
			send_idx_q         <= 8'h00;
			send_end_q         <= 8'h00;
			reply_cnt_q        <= 8'h00;
			reply_ovf_q        <= 1'b0;
			id_code_q          <= 4'h0;
			rsp_len_q          <= 8'h00;
			err_q              <= 1'b0;
		end else begin
			unique case (state_q)
			ST_IDLE: begin
				if (job_ready_q && job.job_valid && job.job_last) begin
					state_q <= ST_DISPATCH;
				end
			end
			ST_DISPATCH: begin
				err_q       <= 1'b0;
				rsp_len_q   <= 8'h00;
				reply_cnt_q <= 8'h00;
				reply_ovf_q <= 1'b0;
				line_addr_o <= job_buf_q[`POS_ADDR][5:0];
				line_last_o <= 1'b1;
				state_q     <= ST_LINE_REQ;
				case (job_buf_q[`POS_CMD]) // R15
				`CMD_ECHO_LIST: begin
					// short or wrong argument gives an empty failed reply
					state_q <= ST_RESPOND;
					if (job_cnt_q >= 8'h02 &&
					    job_buf_q[`POS_ADDR] == `ECHO_ARG) begin
						rsp_len_q <= `ECHO_LEN; // R1
					end else begin
						err_q <= 1'b1;
					end
				end
				`CMD_CTT2: begin
					// the length byte alone sets how much goes out
					if (job_buf_q[`POS_LEN] == 8'h00 ||
					    ctt2_end > {1'b0, job_cnt_q}) begin
						err_q   <= 1'b1;
						state_q <= ST_RESPOND;
					end else begin
						line_op_o          <= LINE_STRING;
						line_data_o        <= job_buf_q[`HDR_LEN]; // R6
						line_last_o        <= (job_buf_q[`POS_LEN] == 8'h01);
						send_idx_q         <= `HDR_LEN;
						send_end_q         <= ctt2_end[7:0]; // R3
						cyclic_hold_o      <= 1'b1; // R7
						cyclic_hold_addr_o <= job_buf_q[`POS_ADDR][5:0];
						line_req_valid_o   <= 1'b1;
					end
				end
				`CMD_VERSION: begin
					rsp_len_q <= `VERSION_LEN; // R9
					state_q   <= ST_RESPOND;
				end
				`CMD_READ_ID: begin
					line_op_o        <= LINE_READ_ID; // R10
					line_req_valid_o <= 1'b1;
				end
				`CMD_READ_XID1: begin
					line_op_o        <= LINE_READ_XID1; // R11
					line_req_valid_o <= 1'b1;
				end
				`CMD_WRITE_XID1: begin
					// no plausibility check on the nibble
					line_op_o        <= LINE_WRITE_XID1;
					line_addr_o      <= `SLAVE_ZERO; // R13
					line_data_o      <= {4'h0, job_buf_q[`POS_ADDR][3:0]}; // R14
					line_req_valid_o <= 1'b1;
				end
				default: begin
					err_q   <= 1'b1;
					state_q <= ST_RESPOND;
				end
				endcase
			end
			ST_LINE_REQ: begin
				if (line_req_ready_i) begin
					if (line_op_o == LINE_STRING &&
					    send_idx_q + 8'h01 < send_end_q) begin
						line_data_o <= job_buf_q[send_idx_q + 8'h01];
						line_last_o <= (send_idx_q + 8'h02 == send_end_q);
						send_idx_q  <= send_idx_q + 8'h01;
					end else begin
						line_req_valid_o <= 1'b0;
						state_q          <= ST_LINE_WAIT;
					end
				end
			end
			ST_LINE_WAIT: begin
				if (line_rsp_valid_i) begin
					if (line_op_o == LINE_STRING) begin
						// overlong replies are dropped, not truncated
						if (reply_cnt_q < `REPLY_MAX) begin
							reply_buf_q[reply_cnt_q] <= line_rsp_data_i; // R5
							reply_cnt_q              <= reply_cnt_q + 8'h01;
						end else begin
							reply_ovf_q <= 1'b1;
						end
						if (line_rsp_last_i) begin
							cyclic_hold_o <= 1'b0; // R7
							state_q       <= ST_RESPOND;
							if (reply_ovf_q || reply_cnt_q >= `REPLY_MAX) begin
								err_q <= 1'b1;
							end else begin
								rsp_len_q <= reply_cnt_q + 8'h02;
							end
						end
					end else begin
						id_code_q <= line_rsp_data_i[3:0];
						rsp_len_q <= (line_op_o == LINE_WRITE_XID1) ?
						             8'h00 : 8'h01;
						state_q   <= ST_RESPOND;
					end
				end
			end
			ST_RESPOND: begin
				if (rsp_end) begin
					state_q <= ST_IDLE;
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// reply byte selection
	// ------------------------------------------------------------
	// echo byte k: slave 2k high nibble (zero in bytes 0 and 16), 2k+1 low; B half from 16
	always_comb begin
		rsp_byte = 8'h00;
		case (job_buf_q[`POS_CMD])
		`CMD_ECHO_LIST: begin
			rsp_byte[3:0] = echo_q[{rsp_idx_q[4:0], 1'b1}]; // R1
			if (rsp_idx_q[3:0] != 4'h0) begin
				rsp_byte[7:4] = echo_q[{rsp_idx_q[4:0], 1'b0}];
			end
		end
		`CMD_VERSION: begin
			rsp_byte = VERSION_TEXT[8'hFF - {rsp_idx_q[4:0], 3'h0} -: 8];
		end
		`CMD_CTT2: begin
			rsp_byte = (rsp_idx_q == 8'h00) ? reply_cnt_q : // R5
			           reply_buf_q[rsp_idx_q - 8'h01];
		end
		default: begin
			rsp_byte = {4'h0, id_code_q}; // R10 R11
		end
		endcase
	end

	assign rsp_free = !rsp_valid_q || job.rsp_ready;
	assign rsp_end  = state_q == ST_RESPOND && rsp_free &&
	                  rsp_idx_q == rsp_len_q && !done_q;

	// ------------------------------------------------------------
	// reply stream and job completion
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= 8'h00;
			rsp_last_q  <= 1'b0;
			rsp_idx_q   <= 8'h00;
			done_q      <= 1'b0;
			fail_q      <= 1'b0;
		end else begin
			done_q <= rsp_end;
			if (rsp_end) begin
				fail_q <= err_q;
			end
			if (state_q != ST_RESPOND) begin
				rsp_idx_q <= 8'h00;
			end
			if (rsp_free) begin
				rsp_valid_q <= 1'b0;
				rsp_last_q  <= 1'b0;
				if (state_q == ST_RESPOND && rsp_idx_q < rsp_len_q) begin
					rsp_valid_q <= 1'b1;
					rsp_data_q  <= rsp_byte;
					rsp_last_q  <= (rsp_idx_q + 8'h01 == rsp_len_q);
					rsp_idx_q   <= rsp_idx_q + 8'h01;
				end
			end
		end
	end

endmodule

// >>> gateway_host.sv
`timescale 1ns/1ps
`include "gateway_cmd_map.svh"

module gateway_host
	import gateway_cmd_pkg::*;
#(
	parameter logic [63:0] TIMEOUT_CYC = `JOB_TIMEOUT_CYC
) (
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	gateway_job_if.host     job,
	input  wire logic       usr_valid_i,
	input  wire logic [7:0] usr_data_i,
	input  wire logic       usr_last_i,
	output      logic       usr_ready_o,
	output      logic       usr_rsp_valid_o,
	output      logic [7:0] usr_rsp_data_o,
	output      logic       usr_rsp_last_o,
	output      logic       usr_done_o,
	output      logic       usr_fail_o,
	output      logic       usr_timeout_o,
	output      logic       usr_trunc_o
);

	logic        job_valid_q;
	logic [7:0]  job_data_q;
	logic        job_last_q;
	logic [7:0]  cnt_q;
	logic        drop_q;
	logic        waiting_q;
	logic [63:0] wait_cnt_q;
	logic        cap;

	assign job.job_valid = job_valid_q;
	assign job.job_data  = job_data_q;
	assign job.job_last  = job_last_q;
	assign job.rsp_ready = 1'b1;

	// ------------------------------------------------------------
	// job forwarding, one byte held at a time
	// ------------------------------------------------------------
	// the 223rd byte is forced last; the user's rest is swallowed
	assign cap = (cnt_q == `JOB_MAX - 8'h01);

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			job_valid_q <= 1'b0;
			job_data_q  <= 8'h00;
			job_last_q  <= 1'b0;
			cnt_q       <= 8'h00;
			drop_q      <= 1'b0;
			usr_ready_o <= 1'b0;
			usr_trunc_o <= 1'b0;
		end else if (job_valid_q) begin
			if (job.job_ready) begin
				job_valid_q <= 1'b0;
				usr_ready_o <= !waiting_q && !job_last_q;
			end
		end else if (usr_ready_o && usr_valid_i) begin
			if (drop_q) begin
				drop_q      <= !usr_last_i;
				usr_ready_o <= !usr_last_i;
			end else begin
				job_valid_q <= 1'b1;
				job_data_q  <= usr_data_i;
				job_last_q  <= usr_last_i || cap; // R4
				drop_q      <= cap && !usr_last_i;
				usr_trunc_o <= cap && !usr_last_i;
				cnt_q       <= (usr_last_i || cap) ? 8'h00 : cnt_q + 8'h01;
				usr_ready_o <= 1'b0;
			end
		end else begin
			usr_ready_o <= !waiting_q || drop_q;
		end
	end

	// ------------------------------------------------------------
	// reply delivery and job timeout
	// ------------------------------------------------------------
	// long string jobs are slow, so the wait is generous
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			waiting_q       <= 1'b0;
			wait_cnt_q      <= 64'h0000_0000_0000_0000;
			usr_rsp_valid_o <= 1'b0;
			usr_rsp_data_o  <= 8'h00;
			usr_rsp_last_o  <= 1'b0;
			usr_done_o      <= 1'b0;
			usr_fail_o      <= 1'b0;
			usr_timeout_o   <= 1'b0;
		end else begin
			usr_rsp_valid_o <= waiting_q && job.rsp_valid;
			usr_rsp_data_o  <= job.rsp_data;
			usr_rsp_last_o  <= job.rsp_last;
			usr_done_o      <= 1'b0;
			if (job_valid_q && job.job_ready && job_last_q) begin
				waiting_q     <= 1'b1;
				wait_cnt_q    <= 64'h0000_0000_0000_0000;
				usr_timeout_o <= 1'b0;
			end else if (waiting_q) begin
				wait_cnt_q <= wait_cnt_q + 64'h0000_0000_0000_0001;
				if (job.done) begin
					waiting_q  <= 1'b0;
					usr_done_o <= 1'b1;
					usr_fail_o <= job.fail;
				end else if (wait_cnt_q >= TIMEOUT_CYC - 64'h1) begin
					waiting_q     <= 1'b0; // R8
					usr_done_o    <= 1'b1;
					usr_fail_o    <= 1'b1;
					usr_timeout_o <= 1'b1;
				end
			end
		end
	end

endmodule

// >>> gateway_job_properties.sv
`timescale 1ns/1ps
`include "gateway_cmd_map.svh"

// ----------------------------------------------------------------
// job stream checker, watches the link between host and gateway
// ----------------------------------------------------------------
module gateway_job_properties (
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	input wire logic       job_valid,
	input wire logic [7:0] job_data,
	input wire logic       job_last,
	input wire logic       job_ready,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last,
	input wire logic       rsp_ready,
	input wire logic       done,
	input wire logic       fail
);
	logic       first_q;
	logic [7:0] cmd_q;
	logic [7:0] jcnt_q;
	logic [7:0] rcnt_q;
	logic [7:0] n_q;

	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	// job side: remember command byte and bytes taken so far
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			first_q <= 1'b1;
			jcnt_q  <= 8'h00;
		end else if (job_valid && job_ready) begin
			first_q <= job_last;
			jcnt_q  <= job_last ? 8'h00 : jcnt_q + 8'h01;
			if (first_q)
				cmd_q <= job_data;
		end
	end

	// reply side: beat index and the count byte of a string reply
	always_ff @(posedge clock_i) begin
		if (!rst_b_i)
			rcnt_q <= 8'h00;
		else if (rsp_valid && rsp_ready) begin
			rcnt_q <= rsp_last ? 8'h00 : rcnt_q + 8'h01;
			if (rcnt_q == 8'h00)
				n_q <= rsp_data;
		end
	end

	property p_hold;
		job_valid && !job_ready |=> job_valid && $stable(job_data);
	endproperty
	a_hold: assert property (p_hold)
		else $error("job byte changed before taken");
	property p_cap;
		job_valid && job_ready |-> jcnt_q < 8'hDF;
	endproperty
	a_cap: assert property (p_cap)
		else $error("job longer than 223 bytes");
	property p_pulse;
		done |=> !done;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("done longer than one cycle");
	property p_end;
		rsp_valid && rsp_ready && rsp_last |=> done && !fail;
	endproperty
	a_end: assert property (p_end)
		else $error("no done after reply");
	property p_busy;
		job_valid && job_ready && job_last |=> !job_ready [*2];
	endproperty
	a_busy: assert property (p_busy)
		else $error("new job taken too early");
	property p_excl;
		rsp_valid |-> !job_ready;
	endproperty
	a_excl: assert property (p_excl)
		else $error("job taken during reply");
	property p_fixed;
		rsp_valid && rsp_last && (cmd_q == `CMD_VERSION ||
		cmd_q == `CMD_ECHO_LIST) |-> rcnt_q == 8'h1F;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed reply not 32 bytes");
	property p_id;
		rsp_valid && (cmd_q == `CMD_READ_ID || cmd_q == `CMD_READ_XID1)
		|-> rsp_last && rsp_data[7:4] == 4'h0;
	endproperty
	a_id: assert property (p_id)
		else $error("bad id reply");
	property p_wr;
		rsp_valid |-> cmd_q != `CMD_WRITE_XID1;
	endproperty
	a_wr: assert property (p_wr)
		else $error("reply after id write");
	property p_str;
		rsp_valid && rsp_last && cmd_q == `CMD_CTT2 && rcnt_q != 8'h00
		|-> rcnt_q == n_q;
	endproperty
	a_str: assert property (p_str)
		else $error("string reply count mismatch");
	property p_zero;
		rsp_valid && cmd_q == `CMD_ECHO_LIST && rcnt_q[3:0] == 4'h0
		|-> rsp_data[7:4] == 4'h0;
	endproperty
	a_zero: assert property (p_zero)
		else $error("slave zero echo not zero");
endmodule

// >>> test_asi_gateway_command_calls.sv
`timescale 1ns/1ps
`include "gateway_cmd_map.svh"

// ----------------------------------------------------------------
// host and gateway joined, user side and line engine driven here
// ----------------------------------------------------------------
module test_asi_gateway_command_calls
	import gateway_cmd_pkg::*;
;
	// arbitrary text, exactly 32 characters
	localparam logic [255:0] VTXT = "test unit fw 1.2 arbitrary text ";
	logic           clock_i, rst_b_i, usr_valid_i, usr_last_i;
	logic [7:0]     usr_data_i, usr_rsp_data_o, line_data_o, lrd;
	logic           usr_ready_o, usr_rsp_valid_o, usr_rsp_last_o;
	logic           usr_done_o, usr_fail_o, usr_timeout_o, usr_trunc_o;
	logic           line_req_valid_o, line_last_o, line_req_ready_i;
	logic           line_rsp_valid_i, line_rsp_last_i, echo_valid_i;
	logic           cyclic_hold_o, lhold, lr_go;
	line_op_type    line_op_o, lop;
	slave_addr_type line_addr_o, cyclic_hold_addr_o, echo_addr_i;
	slave_addr_type laddr, lhaddr;
	logic [3:0]     echo_value_i;
	logic [7:0]     job_q[$], lr_q[$], exp_q[$], rx_q[$], lq_d[$];
	int             err_count, checks, cyc, lr_wait, rx_last;

	gateway_job_if job_if ();
	gateway_cmd #(.VERSION_TEXT(VTXT)) gateway_cmd_inst (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .job(job_if),
		.line_req_valid_o(line_req_valid_o), .line_op_o(line_op_o),
		.line_addr_o(line_addr_o), .line_data_o(line_data_o),
		.line_last_o(line_last_o), .line_req_ready_i(line_req_ready_i),
		.line_rsp_valid_i(line_rsp_valid_i), .line_rsp_data_i(lrd),
		.line_rsp_last_i(line_rsp_last_i), .echo_valid_i(echo_valid_i),
		.echo_addr_i(echo_addr_i), .echo_value_i(echo_value_i),
		.cyclic_hold_o(cyclic_hold_o),
		.cyclic_hold_addr_o(cyclic_hold_addr_o));
	gateway_host #(.TIMEOUT_CYC(64'h0000_0000_0000_00C8)) gateway_host_inst (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .job(job_if),
		.usr_valid_i(usr_valid_i), .usr_data_i(usr_data_i),
		.usr_last_i(usr_last_i), .usr_ready_o(usr_ready_o),
		.usr_rsp_valid_o(usr_rsp_valid_o), .usr_rsp_data_o(usr_rsp_data_o),
		.usr_rsp_last_o(usr_rsp_last_o), .usr_done_o(usr_done_o),
		.usr_fail_o(usr_fail_o), .usr_timeout_o(usr_timeout_o),
		.usr_trunc_o(usr_trunc_o));
	gateway_job_properties gateway_job_properties_inst (
		.clock_i(clock_i), .rst_b_i(rst_b_i),
		.job_valid(job_if.job_valid), .job_data(job_if.job_data),
		.job_last(job_if.job_last), .job_ready(job_if.job_ready),
		.rsp_valid(job_if.rsp_valid), .rsp_data(job_if.rsp_data),
		.rsp_last(job_if.rsp_last), .rsp_ready(job_if.rsp_ready),
		.done(job_if.done), .fail(job_if.fail));

	// ------------------------------------------------------------
	// report helpers
	// ------------------------------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	// clock, cycle ceiling and a line engine that stalls every third cycle
	initial begin
		clock_i = 0;
		forever #4 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		line_req_ready_i <= #1 (cyc % 3 != 2);
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end

	// capture replies and line requests as they pass
	always @(posedge clock_i) begin
		if (usr_rsp_valid_o === 1'b1) begin
			rx_q.push_back(usr_rsp_data_o);
			if (usr_rsp_last_o === 1'b1)
				rx_last = rx_q.size();
		end
		if (line_req_valid_o === 1'b1 && line_req_ready_i === 1'b1) begin
			lq_d.push_back(line_data_o);
			lop    = line_op_o;
			laddr  = line_addr_o;
			lhold  = cyclic_hold_o;
			lhaddr = cyclic_hold_addr_o;
			if (line_last_o === 1'b1)
				lr_go = 1;
		end
	end

	// line replies start only once the whole request has been taken
	initial forever begin
		wait (lr_go);
		lr_go = 0;
		// a slow line holds its answer back by lr_wait cycles
		repeat (lr_wait) @(posedge clock_i);
		foreach (lr_q[i]) begin
			@(posedge clock_i);
			#1 {line_rsp_valid_i, lrd} = {1'b1, lr_q[i]};
			line_rsp_last_i = (i == lr_q.size() - 1);
			@(posedge clock_i);
			#1 {line_rsp_valid_i, line_rsp_last_i} = 2'b00;
		end
	end

	// one job through the user port, then judge fail flag and reply
	task run_job(input logic exp_fail);
		int n;
		rx_q.delete();
		lq_d.delete();
		rx_last = 0;
		foreach (job_q[i]) begin
			{usr_valid_i, usr_data_i} = {1'b1, job_q[i]};
			usr_last_i = (i == job_q.size() - 1);
			for (n = 0; usr_ready_o !== 1'b1 && n < 500; n++)
				@(posedge clock_i) #1;
			chk(8'(usr_ready_o), 8'h01);
			@(posedge clock_i) #1;
		end
		{usr_valid_i, usr_last_i} = 2'b00;
		for (n = 0; usr_done_o !== 1'b1 && n < 2000; n++)
			@(posedge clock_i) #1;
		chk(8'(usr_done_o), 8'h01);
		repeat (3) @(posedge clock_i);
		#1 chk(8'(usr_fail_o), 8'(exp_fail));
		chk(8'(usr_timeout_o), 8'(lr_wait != 0));
		chk(8'(usr_trunc_o), 8'(job_q.size() > `JOB_MAX));
		chk(8'(rx_q.size()), 8'(exp_q.size()));
		chk(8'(rx_last), 8'(exp_q.size()));
		foreach (exp_q[i]) chk(rx_q[i], exp_q[i]);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_version;
		job_q = {`CMD_VERSION};
		lr_q = {};
		exp_q = {};
		for (int i = 0; i < 32; i++) exp_q.push_back(VTXT[255 - 8 * i -: 8]);
		run_job(1'b0);
		$display("test version finished");
	endtask

	// later echo on slave 3 must replace the earlier one
	task t_echo;
		logic [3:0] st[64];
		slave_addr_type a[6];
		logic [3:0] v[6];
		a = '{6'h03, 6'h03, 6'h02, 6'h21, 6'h00, 6'h3F};
		v = '{4'hA, 4'h5, 4'hC, 4'h7, 4'hF, 4'h9};
		foreach (st[i]) st[i] = 4'h0;
		foreach (a[i]) begin
			st[a[i]] = v[i];
			{echo_valid_i, echo_addr_i, echo_value_i} = {1'b1, a[i], v[i]};
			@(posedge clock_i) #1;
		end
		echo_valid_i = 0;
		job_q = {`CMD_ECHO_LIST, `ECHO_ARG};
		exp_q = {};
		for (int k = 0; k < 32; k++)
			exp_q.push_back({(k % 16 == 0) ? 4'h0 : st[2 * k], st[2 * k + 1]});
		run_job(1'b0);
		$display("test echo finished");
	endtask

	task t_refuse;
		job_q = {`CMD_ECHO_LIST, 8'h01};
		exp_q = {};
		run_job(1'b1);
		job_q = {8'h55};
		run_job(1'b1);
		$display("test refuse finished");
	endtask

	task t_ident;
		logic [7:0] c[2];
		line_op_type o[2];
		c = '{`CMD_READ_ID, `CMD_READ_XID1};
		o = '{LINE_READ_ID, LINE_READ_XID1};
		foreach (c[i]) begin
			job_q = {c[i], 8'h25};
			lr_q = {8'hE9 - 8'(i)};
			exp_q = {8'h09 - 8'(i)};
			run_job(1'b0);
			chk(8'(lop), 8'(o[i]));
			chk(8'(laddr), 8'h25);
		end
		$display("test ident finished");
	endtask

	task t_write;
		job_q = {`CMD_WRITE_XID1, 8'hA6};
		lr_q = {8'h00};
		exp_q = {};
		run_job(1'b0);
		chk(lq_d[0], 8'h06);
		chk(8'(laddr), 8'(`SLAVE_ZERO));
		chk(8'(lop), 8'(LINE_WRITE_XID1));
		$display("test write finished");
	endtask

	task t_ctt2;
		job_q = {`CMD_CTT2, 8'h07, 8'h03, 8'h5A, 8'hA5, 8'hC3};
		lr_q = {8'h81, 8'h7E};
		exp_q = {8'h02, 8'h81, 8'h7E};
		run_job(1'b0);
		chk(8'(lq_d.size()), 8'h03);
		foreach (lq_d[i]) chk(lq_d[i], job_q[i + 3]);
		chk(8'(lop), 8'(LINE_STRING));
		chk({lhold, 1'b0, lhaddr}, 8'h87);
		chk(8'(cyclic_hold_o), 8'h00);
		$display("test ctt2 finished");
	endtask

	// the line answers late: the host gives up, the gateway still drains
	task t_timeout;
		job_q = {`CMD_READ_ID, 8'h01};
		lr_q = {8'h03};
		exp_q = {};
		lr_wait = 250;
		run_job(1'b1);
		repeat (80) @(posedge clock_i);
		#1 lr_wait = 0;
		$display("test timeout finished");
	endtask

	// overlong job is cut by the host; the length byte sets what goes out
	task t_cap;
		job_q = {`CMD_CTT2, 8'h07, 8'h01};
		for (int i = 0; i < 222; i++) job_q.push_back(8'(i));
		lr_q = {8'h3C};
		exp_q = {8'h01, 8'h3C};
		run_job(1'b0);
		chk(8'(lq_d.size()), 8'h01);
		chk(lq_d[0], 8'h00);
		$display("test cap finished");
	endtask

	// main sequence
	initial begin
		{rst_b_i, usr_valid_i, usr_last_i, usr_data_i, lr_go} = '0;
		{line_req_ready_i, line_rsp_valid_i, line_rsp_last_i, lrd} = '0;
		{echo_valid_i, echo_addr_i, echo_value_i} = '0;
		{err_count, checks, cyc, lr_wait} = '0;
		repeat (3) @(posedge clock_i);
		#1 rst_b_i = 1;
		t_version();
		t_echo();
		t_refuse();
		t_ident();
		t_timeout();
		t_write();
		t_ctt2();
		t_cap();
		conclude();
	end
endmodule
